// file: bench/tgseq_host.sv
module tgseq_host
    import tgseq_pkg::*;
(
    // bus lines, drive high pulls sda low
    output logic scl_out,
    output logic sda_drv_out,
    input wire logic sda_line_in
);
    timeunit 1ns;
    timeprecision 1ns;
    // ----------------
    // bit level
    // ----------------
    initial begin
        scl_out = 1'b1;
        sda_drv_out = 1'b0;
    end
    // long low phase leaves room for the synchronised ack release
    task automatic slot(input logic b, output logic r);
        #150 sda_drv_out = !b;
        #350 scl_out = 1'b1;
        #150 r = sda_line_in;
        #150 scl_out = 1'b0;
    endtask : slot
    task automatic start;
        #150 sda_drv_out = 1'b0;
        #350 scl_out = 1'b1;
        #150 sda_drv_out = 1'b1;
        #150 scl_out = 1'b0;
    endtask : start
    task automatic stop;
        #150 sda_drv_out = 1'b1;
        #350 scl_out = 1'b1;
        #150 sda_drv_out = 1'b0;
        #150;
    endtask : stop
    task automatic put(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) slot(d[i], r);
        slot(1'b1, r);
        ack = !r;
    endtask : put
    // odd offset keeps bus edges clear of the clock edges
    task automatic write(input logic [2:0] pins, input logic [7:0] a, d, output logic ack);
        logic k;
        #37 start();
        put({TGSEQ_DEV_TYPE, pins, 1'b0}, k);
        put(a, k);
        put(d, ack);
        stop();
    endtask : write
    task automatic read(input logic [2:0] pins, input logic [7:0] a, output logic [7:0] d,
        output logic ack);
        logic r;
        #37 start();
        put({TGSEQ_DEV_TYPE, pins, 1'b0}, ack);
        put(a, r);
        start();
        put({TGSEQ_DEV_TYPE, pins, 1'b1}, r);
        for (int i = 7; i >= 0; i--) slot(1'b1, d[i]);
        slot(1'b1, r);
        stop();
    endtask : read
endmodule : tgseq_host

// file: bench/tgseq_top_sva.sv
module tgseq_top_sva #(
    parameter int SETTLE_CYC = 20,
    parameter int UP_CYC = 30,
    parameter int DOWN_CYC = 40
) (
    input wire logic clock_in,
    input wire logic rst_n_in,
    input wire logic primary_ok_in,
    input wire logic io_ok_in,
    input wire logic core_ok_in,
    input wire logic primary_gate_enable_in,
    input wire logic time_sequence_in,
    input wire logic voltage_sequence_trigger_in,
    input wire logic supply_good_out,
    input wire logic primary_pump_out,
    input wire logic io_pump_out,
    input wire logic core_pump_out
);
    // ----------------
    // run counters
    // ----------------
    int ok_run;
    int good_run;
    int core_on;
    int io_off;
    logic tmode_r;
    default clocking @(posedge clock_in); endclocking
    default disable iff (!rst_n_in);
    // mode follows the last rising sequence edge
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ok_run <= 0;
            good_run <= 0;
            core_on <= 0;
            io_off <= 0;
            tmode_r <= 1'b0;
        end else begin
            ok_run <= primary_ok_in ? ok_run + 1 : 0;
            good_run <= (primary_ok_in && core_ok_in) ? good_run + 1 : 0;
            core_on <= core_pump_out ? core_on + 1 : 0;
            io_off <= io_pump_out ? 0 : io_off + 1;
            tmode_r <= $rose(time_sequence_in) ? 1'b1
                : ($rose(voltage_sequence_trigger_in) ? 1'b0 : tmode_r);
        end
    end
    sequence s_primary_lost;
        $fell(primary_ok_in) ##1 !primary_ok_in [*4];
    endsequence
    chk_good_settle: assert property ($rose(supply_good_out) |-> ok_run >= SETTLE_CYC)
        else $error("supply good rose early");
    chk_good_drop: assert property ($fell(primary_ok_in) |-> ##[1:3] !supply_good_out)
        else $error("supply good held");
    chk_prim_follow: assert property (!primary_gate_enable_in [*5] |-> !primary_pump_out)
        else $error("primary pump without enable");
    chk_prim_lock: assert property (s_primary_lost |-> !(primary_pump_out || io_pump_out
        || core_pump_out))
        else $error("pump on after primary lockout");
    chk_io_lock: assert property (!io_ok_in [*5] |-> !io_pump_out)
        else $error("io pump on in lockout");
    chk_core_lock: assert property (!core_ok_in [*5] |-> !core_pump_out && !io_pump_out)
        else $error("pump on after core lockout");
    chk_core_first: assert property ($rose(io_pump_out) |-> core_pump_out)
        else $error("io before core");
    chk_core_last: assert property ($fell(core_pump_out) |-> !io_pump_out)
        else $error("core off before io");
    chk_up_stagger: assert property ($rose(io_pump_out) && tmode_r
        |-> core_on inside {[UP_CYC - 1:UP_CYC + 1]})
        else $error("io stagger up wrong");
    chk_down_stagger: assert property ($fell(core_pump_out) && good_run > 8
        |-> io_off inside {[DOWN_CYC - 1:DOWN_CYC + 1]})
        else $error("core stagger down wrong");
endmodule : tgseq_top_sva

bind tgseq_top tgseq_top_sva #(.SETTLE_CYC(SETTLE_CYC), .UP_CYC(UP_CYC), .DOWN_CYC(DOWN_CYC))
    u_tgseq_top_sva (.clock_in, .rst_n_in, .primary_ok_in, .io_ok_in, .core_ok_in,
    .primary_gate_enable_in, .time_sequence_in, .voltage_sequence_trigger_in,
    .supply_good_out, .primary_pump_out, .io_pump_out, .core_pump_out);

// file: bench/tgseq_top_test.sv
module tgseq_top_test
    import tgseq_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    // ----------------
    // bench
    // ----------------
    localparam int SET = 20;
    localparam int UP = 30;
    localparam int DN = 40;
    logic clock_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic p_ok = 1'b0, io_ok = 1'b0, c_ok = 1'b0, fb = 1'b0;
    logic pge = 1'b0, tseq = 1'b0, vtrig = 1'b0;
    logic [2:0] pins = 3'h0;
    logic m_p = 1'b0, m_io = 1'b0, m_c = 1'b0, m_un = 1'b0;
    logic ack;
    logic [7:0] rd;
    wire scl, sda_drv, sda_oe, sda_o, good, pp, iop, cp;
    wire sda_line = !(sda_drv || (sda_oe && !sda_o));
    int error_cnt = 0;
    int checks_done = 0;
    int cyc = 0;
    tgseq_top #(.SETTLE_CYC(SET), .UP_CYC(UP), .DOWN_CYC(DN)) u_tgseq_top (
        .clock_in(clock_in), .rst_n_in(rst_n_in), .primary_ok_in(p_ok), .io_ok_in(io_ok),
        .core_ok_in(c_ok), .core_feedback_above_in(fb), .primary_gate_enable_in(pge),
        .time_sequence_in(tseq), .voltage_sequence_trigger_in(vtrig), .scl_in(scl),
        .sda_in(sda_line), .sda_out(sda_o), .sda_oe_out(sda_oe), .addr_pins_in(pins),
        .supply_good_out(good), .primary_pump_out(pp), .io_pump_out(iop), .core_pump_out(cp));
    tgseq_host u_tgseq_host (.scl_out(scl), .sda_drv_out(sda_drv), .sda_line_in(sda_line));
    initial begin
        forever #50 clock_in = !clock_in;
    end
    always @(posedge clock_in) begin
        cyc++;
        if (cyc == 40000) begin
            error_cnt++;
            results();
        end
    end
    task automatic results;
        if (error_cnt == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : results
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic cyc_n(input int n);
        repeat (n) @(posedge clock_in);
    endtask : cyc_n
    task automatic pumps;
        chk({5'h0, pp, iop, cp}, {5'h0, m_p, m_io, m_c}, "pumps");
    endtask : pumps
    task automatic status;
        u_tgseq_host.read(pins, TGSEQ_ADDR_STATUS, rd, ack);
        chk({7'h0, ack}, 8'h01, "status ack");
        chk(rd, {4'h0, m_p, m_io, m_c, m_un}, "status");
    endtask : status
    initial begin
        void'($urandom(99));
        pins <= 3'($urandom());
        repeat (16) @(posedge clock_in);
        rst_n_in <= 1'b1;
        cyc_n(6);
        p_ok <= 1'b1;
        io_ok <= 1'b1;
        c_ok <= 1'b1;
        cyc_n(SET - 4);
        chk({7'h0, good}, 8'h00, "early good");
        cyc_n(10);
        chk({7'h0, good}, 8'h01, "good");
        status();
        u_tgseq_host.read(pins ^ 3'h5, TGSEQ_ADDR_STATUS, rd, ack);
        chk({7'h0, ack}, 8'h00, "foreign ack");
        pge <= 1'b1;
        tseq <= 1'b1;
        cyc_n(6);
        m_p = 1'b1;
        m_c = 1'b1;
        pumps();
        cyc_n(UP + 3);
        m_io = 1'b1;
        pumps();
        status();
        u_tgseq_host.write(pins, TGSEQ_ADDR_STATUS, 8'($urandom()) | 8'h10, ack);
        u_tgseq_host.write(pins, TGSEQ_ADDR_OVERRIDE, 8'h03, ack);
        chk({7'h0, ack}, 8'h00, "locked ack");
        status();
        u_tgseq_host.write(pins, TGSEQ_ADDR_STATUS, TGSEQ_UNLOCK_CODE, ack);
        m_un = 1'b1;
        status();
        for (int c = 1; c < 4; c++) begin
            u_tgseq_host.write(pins, TGSEQ_ADDR_OVERRIDE, 8'(c), ack);
            chk({7'h0, ack}, 8'h01, "override ack");
            m_p = (c == 1);
            m_io = (c == 2);
            pumps();
            cyc_n(DN);
            m_c = (c == 2);
            pumps();
            u_tgseq_host.read(pins, TGSEQ_ADDR_OVERRIDE, rd, ack);
            chk(rd, 8'(c), "override");
            u_tgseq_host.write(pins, TGSEQ_ADDR_OVERRIDE, 8'h00, ack);
            cyc_n(UP + 8);
            m_p = 1'b1;
            m_io = 1'b1;
            m_c = 1'b1;
            pumps();
        end
        tseq <= 1'b0;
        cyc_n(6);
        m_io = 1'b0;
        pumps();
        cyc_n(DN);
        m_c = 1'b0;
        pumps();
        vtrig <= 1'b1;
        cyc_n(6);
        m_c = 1'b1;
        pumps();
        cyc_n(UP + 8);
        pumps();
        fb <= 1'b1;
        cyc_n(6);
        m_io = 1'b1;
        pumps();
        io_ok <= 1'b0;
        cyc_n(6);
        m_io = 1'b0;
        pumps();
        cyc_n(DN);
        m_c = 1'b0;
        pumps();
        vtrig <= 1'b0;
        cyc_n(4);
        io_ok <= 1'b1;
        cyc_n(4);
        vtrig <= 1'b1;
        cyc_n(8);
        m_io = 1'b1;
        m_c = 1'b1;
        pumps();
        vtrig <= 1'b0;
        cyc_n(6);
        m_io = 1'b0;
        pumps();
        cyc_n(DN);
        m_c = 1'b0;
        pumps();
        vtrig <= 1'b1;
        cyc_n(8);
        m_io = 1'b1;
        m_c = 1'b1;
        pumps();
        c_ok <= 1'b0;
        cyc_n(6);
        m_io = 1'b0;
        m_c = 1'b0;
        pumps();
        p_ok <= 1'b0;
        cyc_n(3);
        chk({7'h0, good}, 8'h00, "good drop");
        cyc_n(3);
        m_p = 1'b0;
        pumps();
        results();
    end
endmodule : tgseq_top_test

// file: common/tgseq_pkg.sv
// Behaviour
// - supply good low until settle after lockout
// - supply good drops at once on lockout
// - primary pump follows primary gate enable
// - io/core pumps need good supplies, sequence
// - core up first, core down last
// - time rise: core, then io after stagger
// - time fall: io off, core after stagger
// - voltage trigger rise enables core at once
// - io enabled when feedback exceeds reference
// - voltage fall: io off, core after stagger
// - primary lockout kills all three pumps
// - io lockout: io off, core after stagger
// - core lockout kills core and io together
// - flags mirror internal pump enables
// - status byte layout, upper nibble zero
// - status at 00h, override at ffh
// - random read returns exactly one byte
// - gate flags are read only
// - write unlock gates override writes
// - three address bits match address pins
// - override codes 01, 02, 03 shut gates
// - override 00 releases, resequences gates
// - unlock clear at reset, set by 01h
package tgseq_pkg;
    // ----------------------------------------
    // register map
    // ----------------------------------------
    localparam logic [7:0] TGSEQ_ADDR_STATUS = 8'h00;
    localparam logic [7:0] TGSEQ_ADDR_OVERRIDE = 8'hff;
    localparam int TGSEQ_BIT_PRIMARY = 3;
    localparam int TGSEQ_BIT_IO = 2;
    localparam int TGSEQ_BIT_CORE = 1;
    localparam int TGSEQ_BIT_UNLOCK = 0;
    localparam logic [7:0] TGSEQ_UNLOCK_CODE = 8'h01;
    localparam logic [1:0] TGSEQ_OVR_NONE = 2'h0;
    localparam logic [1:0] TGSEQ_OVR_IO_CORE = 2'h1;
    localparam logic [1:0] TGSEQ_OVR_PRIMARY = 2'h2;
    localparam logic [1:0] TGSEQ_OVR_ALL = 2'h3;
    localparam logic [1:0] TGSEQ_OVR_RESET = 2'h0;
    localparam logic [3:0] TGSEQ_DEV_TYPE = 4'ha;
    // ----------------------------------------
    // timing, 10 MHz clock
    // ----------------------------------------
    localparam int TGSEQ_CLK_NS = 100;
    localparam int TGSEQ_SETTLE_US = 100;
    localparam int TGSEQ_UP_US = 50;
    localparam int TGSEQ_DOWN_US = 50;
    localparam int TGSEQ_SETTLE_CYC = (TGSEQ_SETTLE_US * 1000 + TGSEQ_CLK_NS - 1) / TGSEQ_CLK_NS;
    localparam int TGSEQ_UP_CYC = (TGSEQ_UP_US * 1000 + TGSEQ_CLK_NS - 1) / TGSEQ_CLK_NS;
    localparam int TGSEQ_DOWN_CYC = (TGSEQ_DOWN_US * 1000 + TGSEQ_CLK_NS - 1) / TGSEQ_CLK_NS;
endpackage : tgseq_pkg

// file: common/tgseq_reg_if.sv
interface tgseq_reg_if;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic wr_ok;
    logic [7:0] rdata;
    modport slave (input addr, input wdata, input wr, output wr_ok, output rdata);
    modport master (output addr, output wdata, output wr, input wr_ok, input rdata);
endinterface : tgseq_reg_if

// file: rtl/tgseq_i2c_slave.sv
// two-wire slave: start/stop, slave address, word address, one data byte
module tgseq_i2c_slave
    import tgseq_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_n_in,
    // synchronised bus lines
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic [2:0] addr_pins_in,
    // sda drive, high enables pull-low
    output logic sda_oe_out,
    tgseq_reg_if.master regs
);
    typedef enum logic [2:0] {
        TGSEQ_S_IDLE = 3'b000,
        TGSEQ_S_DEV = 3'b001,
        TGSEQ_S_WADR = 3'b010,
        TGSEQ_S_WDAT = 3'b011,
        TGSEQ_S_RDAT = 3'b100,
        TGSEQ_S_RACK = 3'b101
    } tgseq_i2c_st_t;
    tgseq_i2c_st_t st_r;
    logic scl_d_r, sda_d_r;
    logic [3:0] bit_r;
    logic [7:0] sh_r;
    logic [7:0] ptr_r;
    logic ack_r;
    logic ack_pend_r;
    logic sda_out_r;
    wire scl_rise = scl_in & ~scl_d_r;
    wire scl_fall = ~scl_in & scl_d_r;
    wire start_c = scl_in & scl_d_r & sda_d_r & ~sda_in;
    wire stop_c = scl_in & scl_d_r & ~sda_d_r & sda_in;
    wire [7:0] sh_nxt = {sh_r[6:0], sda_in};
    wire dev_hit = (sh_nxt[7:4] == TGSEQ_DEV_TYPE) && (sh_nxt[3:1] == addr_pins_in);
    wire byte_end = scl_rise && (bit_r == 4'd7);
    wire ack_slot = bit_r == 4'd8;
    assign regs.addr = ptr_r;
    assign regs.wdata = sh_nxt;
    assign regs.wr = byte_end && (st_r == TGSEQ_S_WDAT);
    assign sda_oe_out = ack_r | ~sda_out_r;
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st_r <= TGSEQ_S_IDLE;
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
            bit_r <= 4'd0;
            sh_r <= 8'h00;
            ptr_r <= 8'h00;
            ack_r <= 1'b0;
            ack_pend_r <= 1'b0;
            sda_out_r <= 1'b1;
        end else begin
            scl_d_r <= scl_in;
            sda_d_r <= sda_in;
            // ack goes out on the fall after the 8th bit and drops on the next fall,
            // so sda never moves while scl is high and cannot fake a start
            if (scl_fall) begin
                ack_r <= ack_slot && ack_pend_r && (st_r != TGSEQ_S_IDLE);
            end
            if (start_c) begin
                st_r <= TGSEQ_S_DEV;
                bit_r <= 4'd0;
                ack_r <= 1'b0;
                sda_out_r <= 1'b1;
            end else if (stop_c) begin
                st_r <= TGSEQ_S_IDLE;
                ack_r <= 1'b0;
                sda_out_r <= 1'b1;
            end else if (st_r != TGSEQ_S_IDLE) begin
                if (scl_rise && !ack_slot) begin
                    sh_r <= sh_nxt;
                    bit_r <= bit_r + 4'd1;
                end
                if (byte_end) begin
                    case (st_r)
                        TGSEQ_S_DEV: begin
                            ack_pend_r <= dev_hit;
                        end
                        TGSEQ_S_WADR: begin
                            ptr_r <= sh_nxt;
                            ack_pend_r <= 1'b1;
                        end
                        TGSEQ_S_WDAT: begin
                            ack_pend_r <= regs.wr_ok;
                        end
                        default: begin
                            ack_pend_r <= 1'b0;
                        end
                    endcase
                end
                if (scl_fall && bit_r == 4'd8 && st_r == TGSEQ_S_RACK) begin
                    sda_out_r <= 1'b1;
                end
                if (scl_rise && ack_slot) begin
                    bit_r <= 4'd0;
                    case (st_r)
                        TGSEQ_S_DEV: begin
                            if (!ack_pend_r) begin
                                st_r <= TGSEQ_S_IDLE;
                            end else if (sh_r[0]) begin
                                st_r <= TGSEQ_S_RDAT;
                            end else begin
                                st_r <= TGSEQ_S_WADR;
                            end
                        end
                        TGSEQ_S_WADR: begin
                            st_r <= TGSEQ_S_WDAT;
                        end
                        TGSEQ_S_RACK: begin
                            st_r <= TGSEQ_S_IDLE;
                        end
                        default: begin
                            st_r <= TGSEQ_S_IDLE;
                        end
                    endcase
                    if (st_r == TGSEQ_S_RACK) begin
                        sda_out_r <= 1'b1;
                    end
                end
                if (scl_fall && st_r == TGSEQ_S_RDAT) begin
                    // shift out the single read byte msb first
                    sda_out_r <= regs.rdata[3'd7 - bit_r[2:0]];
                    if (bit_r == 4'd8) begin
                        sda_out_r <= 1'b1;
                    end
                end
                if (byte_end && st_r == TGSEQ_S_RDAT) begin
                    st_r <= TGSEQ_S_RACK;
                end
            end
        end
    end
endmodule : tgseq_i2c_slave

// file: rtl/tgseq_sync.sv
module tgseq_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic [WIDTH-1:0] d_in,
    output logic [WIDTH-1:0] q_out
);
    logic [WIDTH-1:0] meta_r;
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            meta_r <= '0;
            q_out <= '0;
        end else begin
            meta_r <= d_in;
            q_out <= meta_r;
        end
    end
endmodule : tgseq_sync

// file: rtl/tgseq_top.sv
module tgseq_top
    import tgseq_pkg::*;
#(
    parameter int SETTLE_CYC = TGSEQ_SETTLE_CYC,
    parameter int UP_CYC = TGSEQ_UP_CYC,
    parameter int DOWN_CYC = TGSEQ_DOWN_CYC
) (
    // clock and reset
    input wire logic clock_in,
    input wire logic rst_n_in,
    // supply comparators, high when above lockout; core feedback high when above reference
    input wire logic primary_ok_in,
    input wire logic io_ok_in,
    input wire logic core_ok_in,
    input wire logic core_feedback_above_in,
    // sequence controls
    input wire logic primary_gate_enable_in,
    input wire logic time_sequence_in,
    input wire logic voltage_sequence_trigger_in,
    // two-wire bus
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_out,
    input wire logic [2:0] addr_pins_in,
    // outputs
    output logic supply_good_out,
    output logic primary_pump_out,
    output logic io_pump_out,
    output logic core_pump_out
);
    // ----------------------------------------
    // reset and synchronisers
    // ----------------------------------------
    logic [1:0] rst_sync_r;
    logic rst_n;
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rst_sync_r <= 2'b00;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_r[1];

    logic [11:0] raw_s;
    tgseq_sync #(.WIDTH(12)) u_sync (
        .clk_in(clock_in),
        .rst_n_in(rst_n),
        .d_in({primary_ok_in, io_ok_in, core_ok_in, core_feedback_above_in,
            primary_gate_enable_in, time_sequence_in, voltage_sequence_trigger_in,
            scl_in, sda_in, addr_pins_in}),
        .q_out(raw_s)
    );
    wire prim_ok = raw_s[11];
    wire io_ok = raw_s[10];
    wire core_ok = raw_s[9];
    wire fb_above = raw_s[8];
    wire pg_en = raw_s[7];
    wire ts_in = raw_s[6];
    wire vt_in = raw_s[5];
    wire scl_s = raw_s[4];
    wire sda_s = raw_s[3];
    wire [2:0] pins_s = raw_s[2:0];

    // ----------------------------------------
    // supply good with settle time
    // ----------------------------------------
    logic [31:0] settle_r;
    logic good_r;
    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            settle_r <= '0;
            good_r <= 1'b0;
        end else if (!prim_ok) begin
            settle_r <= '0;
            good_r <= 1'b0;
        end else if (settle_r < 32'(SETTLE_CYC)) begin
            settle_r <= settle_r + 32'd1;
        end else begin
            good_r <= 1'b1;
        end
    end
    assign supply_good_out = good_r & prim_ok;

    // ----------------------------------------
    // edge detection of sequence inputs
    // ----------------------------------------
    logic ts_d_r, vt_d_r;
    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            ts_d_r <= 1'b0;
            vt_d_r <= 1'b0;
        end else begin
            ts_d_r <= ts_in;
            vt_d_r <= vt_in;
        end
    end
    wire ts_rise = ts_in & ~ts_d_r;
    wire ts_fall = ~ts_in & ts_d_r;
    wire vt_rise = vt_in & ~vt_d_r;
    wire vt_fall = ~vt_in & vt_d_r;

    // ----------------------------------------
    // registers
    // ----------------------------------------
    tgseq_reg_if rif ();
    logic unlock_r;
    logic [1:0] ovr_r;
    logic primary_r, io_r, core_r;
    wire wr_status = rif.wr && (rif.addr == TGSEQ_ADDR_STATUS);
    wire wr_ovr = rif.wr && (rif.addr == TGSEQ_ADDR_OVERRIDE) && unlock_r;
    assign rif.wr_ok = (rif.addr == TGSEQ_ADDR_OVERRIDE) ? unlock_r : 1'b1;
    wire [7:0] status_byte = {4'h0, primary_r, io_r, core_r, unlock_r};
    assign rif.rdata = (rif.addr == TGSEQ_ADDR_STATUS) ? status_byte :
        (rif.addr == TGSEQ_ADDR_OVERRIDE) ? {6'h00, ovr_r} : 8'h00;
    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            unlock_r <= 1'b0;
            ovr_r <= TGSEQ_OVR_RESET;
        end else begin
            // in the status byte only the unlock bit is writable; gate flags ignore writes
            if (wr_status && rif.wdata == TGSEQ_UNLOCK_CODE) begin
                unlock_r <= 1'b1;
            end
            if (wr_ovr) begin
                ovr_r <= rif.wdata[1:0];
            end
        end
    end

    tgseq_i2c_slave u_bus (
        .clk_in(clock_in),
        .rst_n_in(rst_n),
        .scl_in(scl_s),
        .sda_in(sda_s),
        .addr_pins_in(pins_s),
        .sda_oe_out(sda_oe_out),
        .regs(rif.master)
    );
    assign sda_out = 1'b0;

    // ----------------------------------------
    // sequencing of io and core pumps
    // ----------------------------------------
    // want_r is the requested state of the secondary pair, from either sequence input
    logic want_r;
    logic vmode_r;
    logic [31:0] up_cnt_r, dn_cnt_r;
    wire ovr_io_off = (ovr_r == TGSEQ_OVR_IO_CORE) || (ovr_r == TGSEQ_OVR_ALL);
    wire ovr_pr_off = (ovr_r == TGSEQ_OVR_PRIMARY) || (ovr_r == TGSEQ_OVR_ALL);
    wire sec_ok = supply_good_out & io_ok & core_ok;
    wire run = want_r & sec_ok & ~ovr_io_off;
    wire io_allow = vmode_r ? fb_above : (up_cnt_r >= 32'(UP_CYC));
    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            want_r <= 1'b0;
            vmode_r <= 1'b0;
        end else if (ts_rise | vt_rise) begin
            want_r <= 1'b1;
            vmode_r <= vt_rise;
        end else if (ts_fall | vt_fall) begin
            want_r <= 1'b0;
        end
    end
    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            up_cnt_r <= '0;
            dn_cnt_r <= '0;
            core_r <= 1'b0;
            io_r <= 1'b0;
            primary_r <= 1'b0;
        end else begin
            primary_r <= pg_en & prim_ok & ~ovr_pr_off;
            if (!prim_ok || !core_ok) begin
                core_r <= 1'b0;
                io_r <= 1'b0;
                up_cnt_r <= '0;
                dn_cnt_r <= '0;
            end else if (run) begin
                core_r <= 1'b1;
                dn_cnt_r <= '0;
                if (core_r && up_cnt_r < 32'(UP_CYC)) begin
                    up_cnt_r <= up_cnt_r + 32'd1;
                end
                if (core_r && io_allow) begin
                    io_r <= 1'b1;
                end
            end else begin
                // io off at once, core follows after stagger-down
                io_r <= 1'b0;
                up_cnt_r <= '0;
                if (core_r) begin
                    if (dn_cnt_r >= 32'(DOWN_CYC) - 32'd1) begin
                        core_r <= 1'b0;
                        dn_cnt_r <= '0;
                    end else begin
                        dn_cnt_r <= dn_cnt_r + 32'd1;
                    end
                end
            end
        end
    end
    assign primary_pump_out = primary_r;
    assign io_pump_out = io_r;
    assign core_pump_out = core_r;
endmodule : tgseq_top
